// ### rpbm_pkg.sv
`default_nettype none
package rpbm_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFS_CONFIG   = 5'h00;
    localparam logic [4:0] OFS_KPROG    = 5'h04;
    localparam logic [4:0] OFS_UDATA    = 5'h08;
    localparam logic [4:0] OFS_UPROG    = 5'h0C;
    localparam logic [4:0] OFS_RAMSIZE  = 5'h10;
    // config field layout
    localparam int WAIT_BIT   = 6;
    localparam int ARB_LSB    = 0;
    localparam int ARB_W      = 3;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0040;
    // partition base field layout, 2 KB granules
    localparam int BASE_LSB = 11;
    localparam int BASE_MSB = 15;
    localparam int BASE_W   = BASE_MSB - BASE_LSB + 1;
    localparam logic [31:0] USER_DATA_WINDOW = 32'hBF00_0000;
    localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

    typedef enum logic [1:0] {
        RPBM_ARB_MODE0 = 2'b00,
        RPBM_ARB_MODE1 = 2'b01,
        RPBM_ARB_MODE2 = 2'b10,
        RPBM_ARB_UNDEF = 2'b11
    } rpbm_arb_e;

    typedef enum logic [1:0] {
        RPBM_PART_KDATA = 2'b00,
        RPBM_PART_KPROG = 2'b01,
        RPBM_PART_UDATA = 2'b11,
        RPBM_PART_UPROG = 2'b10
    } rpbm_part_e;

    // partition bases, in granules
    typedef struct packed {
        logic [BASE_W-1:0] kprog;
        logic [BASE_W-1:0] udata;
        logic [BASE_W-1:0] uprog;
    } rpbm_bases_s;
endpackage : rpbm_pkg
`default_nettype wire

// ### rpbm_part_lookup.sv
`default_nettype none
module rpbm_part_lookup
    import rpbm_pkg::*;
#(
    parameter int RAM_AW = 15
) (
    input  wire logic [RAM_AW-1:0]      ramOffset, // ram-relative byte offset
    input  wire rpbm_pkg::rpbm_bases_s  bases,     // programmed bases
    output var rpbm_pkg::rpbm_part_e    partition  // partition holding the offset
);
    import rpbm_pkg::*;

    // a zero base means the partition is absent; preceding one extends
    wire [31:0] offs     = 32'(ramOffset);
    wire [31:0] kprogAdr = {16'h0000, bases.kprog, 11'h000};
    wire [31:0] udataAdr = {16'h0000, bases.udata, 11'h000};
    wire [31:0] uprogAdr = {16'h0000, bases.uprog, 11'h000};
    wire        inUprog  = (bases.uprog != '0) && (offs >= uprogAdr); // R15
    wire        inUdata  = (bases.udata != '0) && (offs >= udataAdr); // R15
    wire        inKprog  = (bases.kprog != '0) && (offs >= kprogAdr); // R15
    // ordering is not checked; a bad order just yields the highest match
    assign partition = inUprog ? RPBM_PART_UPROG :   // R14
                       inUdata ? RPBM_PART_UDATA :
                       inKprog ? RPBM_PART_KPROG : RPBM_PART_KDATA; // R13
endmodule : rpbm_part_lookup
`default_nettype wire

// ### rpbm_top.sv
// Summary of operation
// [R1] wait select bit 1 adds one cpu wait state to data ram accesses; the code takes the wait select from config bit 6
// [R2] arbitration field bits 2-0 pick mode 0, 1 or 2
// [R3] software never writes arbitration codes 011 to 111
// [R4] kernel program base bits 15-11 set kernel program start when non-zero
// [R5] base registers read zero in bits 10-0, 2 KB granules
// [R6] software writes zero to base bits 31-16 and ignores them
// [R7] user data base bits 15-11 set user data start when non-zero
// [R8] non-zero user data base must exceed kernel program base
// [R9] user program base bits 15-11 set user program start when non-zero
// [R10] non-zero user program base must exceed user data base
// [R11] size register returns fixed data ram byte count
// [R12] user data partition appears at 0xBF000000 plus user data base
// [R13] after reset all of ram belongs to kernel mode
// [R14] base ordering is not checked by hardware
// [R15] zero base means absent partition; preceding one extends
//
// Chosen here: register access over Avalon-MM and the register addresses.
`default_nettype none
module rpbm_top
    import rpbm_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = 32'h0000_8000, // data ram bytes
    parameter int          RAM_AW   = 15             // ram offset width
) (
    input  wire logic                  mclk,             // system clock
    input  wire logic                  reset_n,          // async reset
    input  wire logic [4:0]            avsAddress,       // byte address
    input  wire logic                  avsRead,          // read request
    input  wire logic                  avsWrite,         // write request
    input  wire logic [31:0]           avsWritedata,     // write data
    input  wire logic [3:0]            avsByteenable,    // byte lanes
    output logic      [31:0]           avsReaddata,      // read data
    output logic                       avsWaitrequest,   // stall
    input  wire logic [RAM_AW-1:0]     ramOffset,        // current ram access offset
    input  wire logic                  cpuRamReq,        // cpu requests data ram
    output logic                       ramWaitState,     // cpu ram wait state enable
    output logic                       cpuRamStall,      // hold cpu one setup cycle
    output logic      [2:0]            arbitrationMode,  // arbitration code
    output var rpbm_pkg::rpbm_arb_e    arbScheme,        // decoded scheme
    output var rpbm_pkg::rpbm_part_e   ramPartition,     // partition of ramOffset
    output logic      [31:0]           userDataWindow,   // user data base address
    output logic                       kernelOnly        // no user partitions
);
    import rpbm_pkg::*;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [31:0] busMatrixConfig;
    rpbm_bases_s bases;
    logic        ackPhase;
    logic [31:0] next_readdata;

    wire reqAny  = avsRead | avsWrite;
    wire doWrite = avsWrite & ackPhase;
    wire selCfg  = avsAddress == OFS_CONFIG;
    wire selKp   = avsAddress == OFS_KPROG;
    wire selUd   = avsAddress == OFS_UDATA;
    wire selUp   = avsAddress == OFS_UPROG;
    wire selSz   = avsAddress == OFS_RAMSIZE;
    // one wait cycle per access keeps read data registered
    assign avsWaitrequest = reqAny & ~ackPhase;

    wire [31:0] cfgRead = {25'h0, busMatrixConfig[WAIT_BIT], 3'b000, busMatrixConfig[ARB_W-1:0]};
    wire [31:0] kpRead  = {16'h0000, bases.kprog, 11'h000}; // R5
    wire [31:0] udRead  = {16'h0000, bases.udata, 11'h000}; // R5
    wire [31:0] upRead  = {16'h0000, bases.uprog, 11'h000}; // R5
    // unmapped addresses read zero and ignore writes
    assign next_readdata = selCfg ? cfgRead :
                           selKp  ? kpRead  :
                           selUd  ? udRead  :
                           selUp  ? upRead  :
                           selSz  ? RAM_SIZE : UNMAPPED_READ; // R11

    // accept phase toggles so each request takes exactly two edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ackPhase <= 1'b0;
        end else begin
            ackPhase <= reqAny & ~ackPhase;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avsReaddata <= 32'h0000_0000;
        end else if (avsRead && !ackPhase) begin
            avsReaddata <= next_readdata;
        end
    end

    // config: only the wait bit and arbitration field store
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busMatrixConfig <= CONFIG_RESET;
        end else if (doWrite && selCfg) begin
            if (avsByteenable[0]) begin
                busMatrixConfig[WAIT_BIT]  <= avsWritedata[WAIT_BIT];        // R1
                busMatrixConfig[ARB_W-1:0] <= avsWritedata[ARB_W-1:0];       // R2
            end
        end
    end

    // bases: bits 15-11 in byte lane 1; upper bits dropped
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bases <= '0; // R13
        end else if (doWrite && avsByteenable[1]) begin
            if (selKp) bases.kprog <= avsWritedata[BASE_MSB:BASE_LSB]; // R4
            if (selUd) bases.udata <= avsWritedata[BASE_MSB:BASE_LSB]; // R7
            if (selUp) bases.uprog <= avsWritedata[BASE_MSB:BASE_LSB]; // R9
        end
    end

    // ------------------------------------------------------------
    // bus matrix controls
    // ------------------------------------------------------------
    logic setupDone;
    assign ramWaitState    = busMatrixConfig[WAIT_BIT];             // R1
    assign arbitrationMode = busMatrixConfig[ARB_W-1:0];            // R2
    // reserved codes are undefined; flagged so nothing relies on them
    assign arbScheme = (arbitrationMode == 3'b000) ? RPBM_ARB_MODE0 :
                       (arbitrationMode == 3'b001) ? RPBM_ARB_MODE1 :
                       (arbitrationMode == 3'b010) ? RPBM_ARB_MODE2 : RPBM_ARB_UNDEF; // R2
    // with the wait state on, one setup cycle stalls the cpu on the first cycle of each request
    assign cpuRamStall = cpuRamReq & ramWaitState & ~setupDone;     // R1

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            setupDone <= 1'b0;
        end else begin
            setupDone <= cpuRamStall;
        end
    end

    assign userDataWindow = USER_DATA_WINDOW + udRead;             // R12
    assign kernelOnly     = (bases.udata == '0) && (bases.uprog == '0); // R13

    rpbm_part_lookup #(
        .RAM_AW (RAM_AW)
    ) u_lookup (
        .ramOffset (ramOffset),
        .bases     (bases),
        .partition (ramPartition)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_wait_stall;
        @(posedge mclk) disable iff (!reset_n)
        (cpuRamReq && ramWaitState && !setupDone) |-> cpuRamStall ##1 !cpuRamStall;
    endproperty
    a_wait_stall: assert property (p_wait_stall) else $error("wait state not one cycle"); // R1

    property p_no_wait;
        @(posedge mclk) disable iff (!reset_n) !ramWaitState |-> !cpuRamStall;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("stall with zero wait states"); // R1

    property p_arb_write;
        @(posedge mclk) disable iff (!reset_n)
        (doWrite && selCfg && avsByteenable[0]) |=> arbitrationMode == $past(avsWritedata[2:0]);
    endproperty
    a_arb_write: assert property (p_arb_write) else $error("arbitration field not stored"); // R2

    property p_arb_decode;
        @(posedge mclk) disable iff (!reset_n)
        (arbitrationMode == 3'b010) |-> arbScheme == RPBM_ARB_MODE2;
    endproperty
    a_arb_decode: assert property (p_arb_decode) else $error("mode 2 decode wrong"); // R2

    property p_kp_write;
        @(posedge mclk) disable iff (!reset_n)
        (doWrite && selKp && avsByteenable[1]) |=> bases.kprog == $past(avsWritedata[15:11]);
    endproperty
    a_kp_write: assert property (p_kp_write) else $error("kernel program base not stored"); // R4

    property p_ud_write;
        @(posedge mclk) disable iff (!reset_n)
        (doWrite && selUd && avsByteenable[1]) |=> bases.udata == $past(avsWritedata[15:11]);
    endproperty
    a_ud_write: assert property (p_ud_write) else $error("user data base not stored"); // R7

    property p_up_write;
        @(posedge mclk) disable iff (!reset_n)
        (doWrite && selUp && avsByteenable[1]) |=> bases.uprog == $past(avsWritedata[15:11]);
    endproperty
    a_up_write: assert property (p_up_write) else $error("user program base not stored"); // R9

    // an offset between the kernel program base and the next present base is kernel program
    property p_kprog_part;
        @(posedge mclk) disable iff (!reset_n)
        (bases.kprog != '0) && (32'(ramOffset) >= kpRead)
            && ((bases.udata == '0) || (32'(ramOffset) < udRead))
            && ((bases.uprog == '0) || (32'(ramOffset) < upRead)) |-> ramPartition == RPBM_PART_KPROG;
    endproperty
    a_kprog_part: assert property (p_kprog_part) else $error("kernel program partition wrong"); // R4

    property p_low_zero;
        @(posedge mclk) disable iff (!reset_n)
        (avsRead && !avsWaitrequest && !selCfg && !selSz) |-> avsReaddata[10:0] == 11'h000;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("base low bits not zero"); // R5

    property p_size;
        @(posedge mclk) disable iff (!reset_n)
        (avsRead && !avsWaitrequest && selSz) |-> avsReaddata == RAM_SIZE;
    endproperty
    a_size: assert property (p_size) else $error("size register wrong"); // R11

    property p_window;
        @(posedge mclk) disable iff (!reset_n)
        userDataWindow == 32'hBF00_0000 + {16'h0000, bases.udata, 11'h000};
    endproperty
    a_window: assert property (p_window) else $error("user data window wrong"); // R12

    property p_kernel;
        @(posedge mclk) disable iff (!reset_n) kernelOnly && bases.kprog == '0 |-> ramPartition == RPBM_PART_KDATA;
    endproperty
    a_kernel: assert property (p_kernel) else $error("ram not kernel only"); // R13

    property p_answer;
        @(posedge mclk) disable iff (!reset_n) (reqAny && !ackPhase) |=> !avsWaitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    c_stall: cover property (@(posedge mclk) disable iff (!reset_n) cpuRamStall);
    c_uprog: cover property (@(posedge mclk) disable iff (!reset_n) ramPartition == RPBM_PART_UPROG);
    c_write: cover property (@(posedge mclk) disable iff (!reset_n) doWrite && selUd);
endmodule : rpbm_top
`default_nettype wire

// ### rpbm_cpu_model.sv
`default_nettype none
module rpbm_cpu_model #(
    parameter int RAM_AW = 15 // ram offset width
) (
    input  wire logic              mclk,        // system clock
    input  wire logic              reset_n,     // async reset
    input  wire logic              startReq,    // bench asks for one access
    input  wire logic [RAM_AW-1:0] reqOffset,   // offset of that access
    input  wire logic              cpuRamStall, // setup stall from the block
    output logic                   cpuRamReq,   // access request level
    output logic      [RAM_AW-1:0] ramOffset,   // access offset
    output var int                 stallCount   // stall cycles seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // request held through a stall, then dropped for at least one cycle;
    // a released offset is inverted so nothing leans on a stale address
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cpuRamReq  <= 1'b0;
            ramOffset  <= '0;
            stallCount <= 0;
        end else if (cpuRamReq && cpuRamStall) begin
            stallCount <= stallCount + 1;
        end else if (cpuRamReq) begin
            cpuRamReq <= 1'b0;
            ramOffset <= ~ramOffset;
        end else if (startReq) begin
            cpuRamReq <= 1'b1;
            ramOffset <= reqOffset;
        end
    end
endmodule : rpbm_cpu_model
`default_nettype wire

// ### rpbm_top_tb_top.sv
`default_nettype none
module rpbm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rpbm_pkg::*;
    // a 16 KB part, so the size value differs from the default
    localparam int          AW = 14;
    localparam logic [31:0] SZ = 32'h0000_4000;
    typedef struct packed { logic [4:0] a; logic [31:0] w; logic [31:0] e; } rpbm_row_s;
    logic          mclk, reset_n, avsRead, avsWrite, avsWaitrequest, startReq;
    logic          cpuRamReq, cpuRamStall, ramWaitState, kernelOnly;
    logic [4:0]    avsAddress;
    logic [3:0]    avsByteenable;
    logic [31:0]   avsWritedata, avsReaddata, userDataWindow, rd;
    logic [2:0]    arbitrationMode;
    logic [AW-1:0] ramOffset, reqOffset;
    rpbm_arb_e     arbScheme;
    rpbm_part_e    ramPartition;
    int            mismatches = 0, total_checks = 0, stallCount, s0;
    // write value beside the value read back; bases are ordered as software must keep them
    rpbm_row_s     rows [6] = '{'{OFS_CONFIG, 32'h0000_0041, 32'h0000_0041},
        '{OFS_KPROG, 32'h0000_0FFF, 32'h0000_0800}, '{OFS_UDATA, 32'h0000_17FF, 32'h0000_1000},
        '{OFS_UPROG, 32'h0000_1800, 32'h0000_1800}, '{OFS_RAMSIZE, 32'h0000_0000, SZ},
        '{5'h14, 32'h0000_1234, 32'h0000_0000}};

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    rpbm_top #(.RAM_SIZE(SZ), .RAM_AW(AW)) dut (.mclk(mclk), .reset_n(reset_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .ramOffset(ramOffset),
        .cpuRamReq(cpuRamReq), .ramWaitState(ramWaitState), .cpuRamStall(cpuRamStall),
        .arbitrationMode(arbitrationMode), .arbScheme(arbScheme), .ramPartition(ramPartition),
        .userDataWindow(userDataWindow), .kernelOnly(kernelOnly));
    rpbm_cpu_model #(.RAM_AW(AW)) cpuModel (.mclk(mclk), .reset_n(reset_n), .startReq(startReq),
        .reqOffset(reqOffset), .cpuRamStall(cpuRamStall), .cpuRamReq(cpuRamReq), .ramOffset(ramOffset),
        .stallCount(stallCount));

    //----------------------------------------
    // tasks
    //----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one avalon access; entered just after an edge, leaves one idle cycle behind
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avsAddress   <= a;
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= !wr;
        // no local limit: a wait that never ends is cut off by the watchdog alone
        do begin
            @(posedge mclk);
        end while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        @(posedge mclk);
    endtask : bus

    // one cpu access: partition seen while it is up, stall cycles counted to its end
    task automatic cpu(input logic [AW-1:0] off, input rpbm_part_e p, input int st);
        s0 = stallCount;
        reqOffset <= off;
        startReq  <= 1'b1;
        @(posedge mclk);
        startReq  <= 1'b0;
        @(negedge mclk);
        chk(32'(ramPartition), 32'(p));
        for (int n = 0; n < 20 && cpuRamReq === 1'b1; n++) @(negedge mclk);
        chk(32'(stallCount - s0), 32'(st));
        @(posedge mclk);
    endtask : cpu

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // a hang is cut off well past the roughly 90 cycles the sequence needs
    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    //----------------------------------------
    // sequence
    //----------------------------------------
    initial begin
        {reset_n, avsRead, avsWrite, startReq} = 4'h0;
        {avsAddress, avsWritedata, reqOffset} = '0;
        avsByteenable = 4'hF;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        bus(0, OFS_CONFIG, '0);
        chk(rd, CONFIG_RESET);
        chk(32'(kernelOnly), 32'h1);
        cpu(14'h0100, RPBM_PART_KDATA, 1);
        foreach (rows[i]) begin
            bus(1, rows[i].a, rows[i].w);
            bus(0, rows[i].a, '0);
            chk(rd, rows[i].e);
        end
        chk(userDataWindow, 32'hBF00_1000);
        chk(32'(kernelOnly), 32'h0);
        cpu(14'h07FC, RPBM_PART_KDATA, 1);
        cpu(14'h0800, RPBM_PART_KPROG, 1);
        cpu(14'h1000, RPBM_PART_UDATA, 1);
        cpu(14'h3FFC, RPBM_PART_UPROG, 1);
        // arbitration codes 000..010 only, wait state off
        for (int i = 0; i < 3; i++) begin
            bus(1, OFS_CONFIG, 32'(i));
            chk(32'(arbitrationMode), 32'(i));
            chk(32'(arbScheme), 32'(i));
            chk(32'(ramWaitState), 32'h0);
        end
        cpu(14'h1000, RPBM_PART_UDATA, 0);
        bus(1, OFS_UDATA, '0);
        cpu(14'h1000, RPBM_PART_KPROG, 0);
        reset_n <= 1'b0;
        @(posedge mclk);
        reset_n <= 1'b1;
        bus(0, OFS_UPROG, '0);
        chk(rd, '0);
        bus(0, OFS_CONFIG, '0);
        chk(rd, CONFIG_RESET);
        summarize();
    end
endmodule : rpbm_top_tb_top
`default_nettype wire
